//--- core/qub_host_port.sv
// Host bus front end with strap-selected bus style for four serial channels
module qub_host_port #(
    parameter int N_CHAN = qub_pkg::QUB_N_CHAN
) (
    input  wire logic                                         i_clk_sys,
    input  wire logic                                         i_rst_n,
    input  wire logic                                         i_style_strap,
    input  wire logic                                         i_reset_pin,
    input  wire logic                                         i_read_strobe_low,
    input  wire logic                                         i_write_strobe_low,
    input  wire logic                                         i_first_channel_select_low,
    input  wire logic [qub_pkg::QUB_CHA_W-1:0]                i_channel_address_bits,
    input  wire logic                                         i_fourth_channel_select_low,
    input  wire logic [qub_pkg::QUB_ADDR_W-1:0]               i_register_address_bits,
    input  wire logic [qub_pkg::QUB_DATA_W-1:0]               i_data,
    input  wire logic [qub_pkg::QUB_N_CHAN-1:0]               i_chan_irq,
    input  wire logic [qub_pkg::QUB_N_CHAN-1:0][qub_pkg::QUB_DATA_W-1:0] i_rd_data,
    output logic [qub_pkg::QUB_DATA_W-1:0]                    o_data,
    output logic                                              o_data_oe,
    output qub_pkg::qub_wr_t                                  o_wr,
    output qub_pkg::qub_rd_t                                  o_rd,
    output logic                                              o_chan_reset,
    output logic [qub_pkg::QUB_N_CHAN-1:0]                    o_chan_irq,
    output logic                                              o_irq,
    output logic                                              o_irq_oe,
    output logic                                              o_style_strobe
);
    import qub_pkg::*;

    // Only four channels fit two channel bits and four select pins
    if (N_CHAN != QUB_N_CHAN) begin : g_bad_chan
        $error("qub_host_port: channel count must be four");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic      rst_meta;
    logic      rst_sync;
    qub_pins_t pin_raw;
    qub_pins_t pin_meta;
    qub_pins_t pin_cur;
    qub_pins_t pin_prev;

    assign pin_raw = '{strap: i_style_strap, reset_pin: i_reset_pin,
        read_strobe_low: i_read_strobe_low, write_strobe_low: i_write_strobe_low,
        first_channel_select_low: i_first_channel_select_low,
        channel_address_bits: i_channel_address_bits,
        fourth_channel_select_low: i_fourth_channel_select_low,
        register_address_bits: i_register_address_bits, data: i_data};

    // Two-flop reset release
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // strap defaults high
    // Pin sync, third stage for edges and read/write-line style write capture
    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            pin_meta <= QUB_PINS_RST;
            pin_cur  <= QUB_PINS_RST;
            pin_prev <= QUB_PINS_RST;
        end else begin
            pin_meta <= pin_raw;
            pin_cur  <= pin_meta;
            pin_prev <= pin_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus style decode

    logic                  style_strobe;
    logic [N_CHAN-1:0]     sel_strobe;
    logic [N_CHAN-1:0]     sel_rw;
    logic [N_CHAN-1:0]     sel_rw_prev;
    logic [N_CHAN-1:0]     sel_now;
    logic                  rd_fall;
    logic                  wr_fall;
    logic                  cs_fall;
    logic                  cs_rise;
    logic                  rd_start;
    logic                  wr_event;
    logic                  rd_active;
    logic [N_CHAN-1:0]     wr_chan;
    logic [QUB_ADDR_W-1:0] wr_addr;
    logic [QUB_DATA_W-1:0] wr_data;
    logic [QUB_DATA_W-1:0] rd_mux;
    logic                  next_reset;

    assign style_strobe = (pin_cur.strap == QUB_STYLE_STROBE);

    assign sel_strobe = ~{pin_cur.fourth_channel_select_low, pin_cur.channel_address_bits[1],
                          pin_cur.channel_address_bits[0], pin_cur.first_channel_select_low};

    assign sel_rw      = pin_cur.first_channel_select_low ? QUB_CHAN_NONE
                       : (QUB_CHAN_ONE << pin_cur.channel_address_bits);
    assign sel_rw_prev = pin_prev.first_channel_select_low ? QUB_CHAN_NONE
                       : (QUB_CHAN_ONE << pin_prev.channel_address_bits);
    assign sel_now     = style_strobe ? sel_strobe : sel_rw;

    // Strobe edges on the synchronised pins
    assign rd_fall = pin_prev.read_strobe_low & ~pin_cur.read_strobe_low;
    assign wr_fall = pin_prev.write_strobe_low & ~pin_cur.write_strobe_low;
    assign cs_fall = pin_prev.first_channel_select_low & ~pin_cur.first_channel_select_low;
    assign cs_rise = ~pin_prev.first_channel_select_low & pin_cur.first_channel_select_low;

    // read/write-line style: read pin unused, direction from write pin
    assign rd_start = style_strobe ? (rd_fall & (|sel_strobe))
                    : (cs_fall & (pin_cur.write_strobe_low == QUB_RW_READ));
    assign rd_active = style_strobe ? (~pin_cur.read_strobe_low & (|sel_strobe))
                     : (~pin_cur.first_channel_select_low & (pin_cur.write_strobe_low == QUB_RW_READ));

    // write on falling strobe; other style at end of select
    assign wr_event = style_strobe ? (wr_fall & (|sel_strobe))
                    : (cs_rise & (pin_prev.write_strobe_low != QUB_RW_READ));
    assign wr_chan  = style_strobe ? sel_strobe : sel_rw_prev;
    assign wr_addr  = style_strobe ? pin_cur.register_address_bits : pin_prev.register_address_bits;
    assign wr_data  = style_strobe ? pin_cur.data : pin_prev.data;

    always_comb begin
        rd_mux = QUB_DATA_RST;
        for (int i = 0; i < N_CHAN; i++) begin
            if (sel_now[i]) begin
                rd_mux = rd_mux | i_rd_data[i];
            end
        end
    end

    assign next_reset = style_strobe ? pin_cur.reset_pin : ~pin_cur.reset_pin;

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // Host data bus and requests
    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            o_data    <= QUB_DATA_RST;
            o_data_oe <= 1'b0;
            o_wr      <= '0;
            o_rd      <= '0;
        end else begin
            o_data    <= rd_mux;
            o_data_oe <= rd_active;
            o_wr      <= '{valid: wr_event, chan: wr_chan, addr: wr_addr, data: wr_data};
            o_rd      <= '{valid: rd_start, chan: sel_now, addr: pin_cur.register_address_bits};
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            o_chan_reset   <= 1'b1;
            o_chan_irq     <= QUB_CHAN_NONE;
            o_irq          <= 1'b0;
            o_irq_oe       <= 1'b0;
            o_style_strobe <= QUB_STRAP_RST;
        end else begin
            o_chan_reset   <= next_reset;
            o_chan_irq     <= style_strobe ? i_chan_irq : QUB_CHAN_NONE;
            o_irq          <= ~style_strobe & (|i_chan_irq);
            o_irq_oe       <= ~style_strobe & (|i_chan_irq);
            o_style_strobe <= style_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_sync);

    sequence s_strobe_read;
        style_strobe && rd_fall && (|sel_strobe);
    endsequence

    sequence s_read_answer;
        o_rd.valid && o_data_oe && (o_rd.chan == $past(sel_strobe));
    endsequence

    property p_style_irq;
        !style_strobe |=> (o_chan_irq == QUB_CHAN_NONE);
    endproperty
    a_style_irq: assert property (p_style_irq) else $error("channel irqs active in rw style");

    property p_rw_reset;
        !style_strobe |=> (o_chan_reset == !$past(pin_cur.reset_pin));
    endproperty
    a_rw_reset: assert property (p_rw_reset) else $error("reset polarity wrong in rw style");

    property p_rw_ignore_read;
        (!style_strobe && pin_cur.first_channel_select_low) |=> !o_data_oe && !o_rd.valid;
    endproperty
    a_rw_ignore_read: assert property (p_rw_ignore_read) else $error("drive without select");

    property p_shared_irq;
        ##1 (o_irq_oe == $past(!style_strobe && (|i_chan_irq))) && (o_irq == o_irq_oe);
    endproperty
    a_shared_irq: assert property (p_shared_irq) else $error("shared irq mismatch");

    property p_reg_addr;
        o_rd.valid |-> (o_rd.addr == $past(pin_cur.register_address_bits));
    endproperty
    a_reg_addr: assert property (p_reg_addr) else $error("read register address wrong");

    property p_rw_chan;
        (!style_strobe && cs_fall && pin_cur.write_strobe_low)
            |=> o_rd.valid && (o_rd.chan == (QUB_CHAN_ONE << $past(pin_cur.channel_address_bits)));
    endproperty
    a_rw_chan: assert property (p_rw_chan) else $error("channel bits decode wrong");

    property p_strobe_no_sel;
        (style_strobe && (sel_strobe == QUB_CHAN_NONE)) |=> !o_rd.valid && !o_wr.valid && !o_data_oe;
    endproperty
    a_strobe_no_sel: assert property (p_strobe_no_sel) else $error("transfer without select");

    property p_strobe_read;
        s_strobe_read |=> s_read_answer;
    endproperty
    a_strobe_read: assert property (p_strobe_read) else $error("read strobe not answered");

    property p_strobe_write;
        (style_strobe && wr_fall && (|sel_strobe))
            |=> o_wr.valid && (o_wr.data == $past(pin_cur.data)) && (o_wr.chan == $past(sel_strobe));
    endproperty
    a_strobe_write: assert property (p_strobe_write) else $error("write strobe not stored");

    property p_first_sel;
        (style_strobe && rd_fall && !pin_cur.first_channel_select_low) |=> o_rd.chan[0];
    endproperty
    a_first_sel: assert property (p_first_sel) else $error("first channel select ignored");

    property p_strap_default;
        $rose(rst_sync) |-> style_strobe;
    endproperty
    a_strap_default: assert property (p_strap_default) else $error("strap default wrong");

endmodule : qub_host_port

//--- dv/qub_host_bfm.sv
// Host processor model driving the parallel bus pins
module qub_host_bfm (
    input  wire logic       i_clk_sys,
    output logic            o_read_strobe_low,
    output logic            o_write_strobe_low,
    output logic            o_first_channel_select_low,
    output logic [1:0]      o_channel_address_bits,
    output logic            o_fourth_channel_select_low,
    output logic [2:0]      o_register_address_bits,
    output logic [7:0]      o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins at time zero
    initial begin
        {o_read_strobe_low, o_write_strobe_low, o_first_channel_select_low} = 3'h7;
        {o_channel_address_bits, o_fourth_channel_select_low} = 3'h7;
        o_register_address_bits = 3'h0;
        o_data = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One bus cycle; hold sets strobe width, so prompt or slow
    task xfer(input logic rw, input logic rd, input logic [1:0] ch, input logic [2:0] a,
              input logic [7:0] d, input logic sel, input int hold);
        @(negedge i_clk_sys);
        o_register_address_bits = a;
        o_data = rd ? ~o_data : d;  // Read: host not driving, pattern moves
        if (rw) begin
            o_channel_address_bits = ch;
            o_write_strobe_low = rd;
        end else begin
            o_first_channel_select_low = !(sel && ch == 2'h0);
            o_channel_address_bits = ~({ch == 2'h2, ch == 2'h1} & {2{sel}});
            o_fourth_channel_select_low = !(sel && ch == 2'h3);
        end
        repeat (3) @(negedge i_clk_sys);
        if (rw) begin
            o_first_channel_select_low = !sel;
            o_read_strobe_low = 1'b0;  // Must be ignored in this style
        end else if (rd) begin
            o_read_strobe_low = 1'b0;
        end else begin
            o_write_strobe_low = 1'b0;
        end
        repeat (hold) @(negedge i_clk_sys);
        o_read_strobe_low = 1'b1;
        if (rw) o_first_channel_select_low = 1'b1;
        else o_write_strobe_low = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        // Release: selects high, data shows inverse of last value
        {o_write_strobe_low, o_first_channel_select_low, o_fourth_channel_select_low} = 3'h7;
        o_channel_address_bits = 2'h3;
        o_data = ~o_data;
    endtask : xfer
endmodule : qub_host_bfm

//--- dv/qub_host_port_tb.sv
// Self-checking bench for the host bus front end
module qub_host_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import qub_pkg::*;
    typedef struct packed {logic rd; logic [3:0] ch; logic [2:0] a; logic [7:0] d;} qub_exp_t;

    logic clk_sys = 1'b0, rst_n = 1'b0, strap = 1'b1, strap_z = 1'b1, reset_pin = 1'b0;
    logic [3:0]      chan_irq = 4'h0;
    logic [3:0][7:0] rd_data  = '0;
    logic            rstb, wstb, sel0, sel3, data_oe, chan_reset, irq, irq_oe, style;
    logic [1:0]      chb;
    logic [2:0]      addr;
    logic [7:0]      hdata, data_out;
    logic [3:0]      chan_irq_o;
    qub_wr_t         wr;
    qub_rd_t         rd;
    tri1             style_w;  // Strap pin with pull-up
    int              n_mismatch = 0, checks = 0;
    qub_exp_t        q[$];

    assign style_w = strap_z ? 1'bz : strap;
    // Clock 25 ns
    always #12.5 clk_sys = ~clk_sys;

    qub_host_bfm host (.i_clk_sys(clk_sys), .o_read_strobe_low(rstb), .o_write_strobe_low(wstb),
        .o_first_channel_select_low(sel0), .o_channel_address_bits(chb), .o_fourth_channel_select_low(sel3),
        .o_register_address_bits(addr), .o_data(hdata));
    qub_host_port uut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_style_strap(style_w), .i_reset_pin(reset_pin),
        .i_read_strobe_low(rstb), .i_write_strobe_low(wstb), .i_first_channel_select_low(sel0),
        .i_channel_address_bits(chb), .i_fourth_channel_select_low(sel3), .i_register_address_bits(addr),
        .i_data(hdata), .i_chan_irq(chan_irq), .i_rd_data(rd_data), .o_data(data_out), .o_data_oe(data_oe),
        .o_wr(wr), .o_rd(rd), .o_chan_reset(chan_reset), .o_chan_irq(chan_irq_o), .o_irq(irq),
        .o_irq_oe(irq_oe), .o_style_strobe(style));

    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task end_sim;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // Note expectation, run cycle, wait for answer
    task xfer(input logic rw, input logic rdo, input logic [1:0] ch, input logic sel);
        logic [2:0] a;
        logic [7:0] d;
        a = 3'($urandom);
        d = rdo ? rd_data[ch] : 8'($urandom);
        if (sel) q.push_back('{rdo, 4'h1 << ch, a, d});
        host.xfer(rw, rdo, ch, a, d, sel, 3 + $urandom_range(5));
        for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk_sys);
        if (q.size() > 0) begin
            n_mismatch++;
            end_sim();
        end
        // Data bus released once the strobe or select is back high
        chk(16'(data_oe), 16'h0);
    endtask : xfer

    ////////////////////////////////////////////////////////////////////////////
    // Watcher: pop oldest note on each transfer pulse
    always begin : watch
        qub_exp_t e;
        @(posedge clk_sys);
        #1;
        if (wr.valid === 1'b1 || rd.valid === 1'b1) begin
            if (q.size() == 0) begin
                chk(16'h1, 16'h0);
            end else begin
                e = q.pop_front();
                chk(16'({rd.valid, wr.valid}), 16'({e.rd, !e.rd}));
                if (e.rd) begin
                    chk(16'({rd.chan, rd.addr, data_oe}), 16'({e.ch, e.a, 1'b1}));
                    @(posedge clk_sys);
                    #1;
                    chk(16'(data_out), 16'(e.d));
                end else begin
                    chk(16'({wr.chan, wr.addr, wr.data}), 16'({e.ch, e.a, e.d}));
                end
            end
        end
    end

    // Main sequence, inputs change at falling edge
    initial begin
        void'($urandom(32'h1bb7));
        for (int c = 0; c < 4; c++) rd_data[c] = 8'($urandom);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk(16'(style), 16'h1);
        strap_z = 1'b0;
        for (int s = 0; s < 2; s++) begin
            strap = (s == 0) ? QUB_STYLE_STROBE : ~QUB_STYLE_STROBE;
            reset_pin = s[0];  // Idle reset level per style
            repeat (8) @(negedge clk_sys);
            chk(16'({style, chan_reset}), 16'({strap, 1'b0}));
            for (int c = 0; c < 4; c++) begin
                xfer(s[0], 1'b0, 2'(c), 1'b1);
                xfer(s[0], 1'b1, 2'(c), 1'b1);
            end
            xfer(s[0], 1'b1, 2'($urandom), 1'b0);
            xfer(s[0], 1'b0, 2'($urandom), 1'b0);
            reset_pin = !s[0];
            repeat (5) @(negedge clk_sys);
            chk(16'(chan_reset), 16'h1);
            reset_pin = s[0];
            repeat (5) @(negedge clk_sys);
            chk(16'(chan_reset), 16'h0);
            for (int k = 0; k < 6; k++) begin
                chan_irq = (k < 4) ? 4'h1 << k : (k == 4 ? 4'($urandom) : 4'h0);
                repeat (2) @(negedge clk_sys);
                chk(16'({chan_irq_o, irq, irq_oe}), 16'(s[0] ? {4'h0, {2{|chan_irq}}} : {chan_irq, 2'b00}));
            end
            $display("test style %0d done", s);
        end
        end_sim();
    end
endmodule : qub_host_port_tb

//--- inc/qub_pkg.sv
// Constants, pin and request structs for the quad serial host port
//
// Contract
// - Strap high selects separate-strobe bus style, strap low selects read/write-line style.
// - Read/write-line style: write pin is direction, reset is active low, read ignored.
// - Read/write-line style: four channel interrupts OR onto one open-source output.
// - Three register address bits pick the register inside the chosen channel.
// - Read/write-line style: two channel bits pick a channel only while select low.
// - Separate-strobe style: channel bit pins act as second and third channel selects.
// - Read/write-line style: low common select enables all channels; bits pick one.
// - Separate-strobe style: transfers happen only for channels whose select is low.
// - Separate-strobe style: common select pin is the first channel's select.
// - Separate-strobe style: falling read strobe drives addressed register onto data bus.
// - Separate-strobe style: falling write strobe stores data bus into addressed register.
package qub_pkg;

    localparam int          QUB_N_CHAN       = 4;
    localparam int          QUB_DATA_W       = 8;
    localparam int          QUB_ADDR_W       = 3;
    localparam int          QUB_CHA_W        = 2;
    localparam logic        QUB_STYLE_STROBE = 1'b1;  // Strap level for separate strobes
    localparam logic        QUB_STRAP_RST    = 1'b1;  // Pulled-up strap value
    localparam logic        QUB_RW_READ      = 1'b1;  // Direction pin level for a read
    localparam logic [3:0]  QUB_CHAN_ONE     = 4'h1;
    localparam logic [3:0]  QUB_CHAN_NONE    = 4'h0;
    localparam logic [7:0]  QUB_DATA_RST     = 8'h00;

    // Host pins as sampled, all captured together
    typedef struct packed {
        logic                  strap;
        logic                  reset_pin;
        logic                  read_strobe_low;
        logic                  write_strobe_low;
        logic                  first_channel_select_low;
        logic [QUB_CHA_W-1:0]  channel_address_bits;
        logic                  fourth_channel_select_low;
        logic [QUB_ADDR_W-1:0] register_address_bits;
        logic [QUB_DATA_W-1:0] data;
    } qub_pins_t;

    localparam qub_pins_t QUB_PINS_RST = '{strap: QUB_STRAP_RST, reset_pin: 1'b0,
        read_strobe_low: 1'b1, write_strobe_low: 1'b1, first_channel_select_low: 1'b1,
        channel_address_bits: 2'h0, fourth_channel_select_low: 1'b1,
        register_address_bits: 3'h0, data: 8'h00};

    // Register write toward the channel cores
    typedef struct packed {
        logic                  valid;
        logic [QUB_N_CHAN-1:0] chan;
        logic [QUB_ADDR_W-1:0] addr;
        logic [QUB_DATA_W-1:0] data;
    } qub_wr_t;

    // Register read toward the channel cores
    typedef struct packed {
        logic                  valid;
        logic [QUB_N_CHAN-1:0] chan;
        logic [QUB_ADDR_W-1:0] addr;
    } qub_rd_t;

endpackage : qub_pkg
